// *** core/point_validity_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - periodically force enrolled invalid flags to one
// - flag address zero excludes point
// - check every enrolled flag each interval
// - set flag at check increments counter
// - one failure counter per point
// - counter equals threshold reports point invalid
// - cleared flag resets counter, point valid
// - zero invalidation cycle, check interval or failure threshold disables all checking
// - zero scan period produces no events
// - scan events every scan period milliseconds
// - per-type scan enable gates its events
module point_validity_monitor import pvm_pkg::*; #(
  parameter int unsigned N_POINTS = 8,
  parameter int unsigned MS_DIV = MS_CYCLES,
  parameter int unsigned SEC_DIV = SEC_MS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire pvm_cfg_t cfg,
  input wire logic [N_POINTS-1:0] flag_addr_nonzero,
  input wire logic [N_POINTS-1:0] flag_clear,
  input wire logic [N_TYPES-1:0] type_scan_enable,
  output logic [N_POINTS-1:0] invalid_flag,
  output logic [N_POINTS-1:0] point_invalid,
  output logic [N_TYPES-1:0] scan_event,
  output logic check_pulse,
  output logic monitor_active
);

  // ****************************************
  // time base dividers
  // ****************************************
  logic [31:0] ms_cnt_q;
  logic [15:0] sec_cnt_q;
  logic ms_tick;
  logic sec_tick;
  logic enabled;

  assign ms_tick = (ms_cnt_q == 32'(MS_DIV - 1));
  assign sec_tick = ms_tick && (sec_cnt_q == 16'(SEC_DIV - 1));
  assign enabled = (cfg.invalidation_cycle_seconds != CFG_ZERO) &&
                   (cfg.validity_check_interval != CFG_ZERO) &&
                   (cfg.failure_threshold != CFG_ZERO);

  always_ff @(posedge clk) begin
    if (!rstn || ms_tick) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || sec_tick) begin
      sec_cnt_q <= CFG_ZERO;
    end else if (ms_tick) begin
      sec_cnt_q <= sec_cnt_q + CFG_ONE;
    end
  end

  // ****************************************
  // state
  // ****************************************
  pvm_state_t state_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= enabled ? ST_RUN : ST_OFF;
        ST_RUN: state_q <= enabled ? ST_RUN : ST_OFF;
        ST_OFF: state_q <= enabled ? ST_RUN : ST_OFF;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic run;
  assign run = (state_q == ST_RUN) && enabled;

  // ****************************************
  // invalidation and check timers
  // ****************************************
  logic [CFG_W-1:0] inv_sec_q;
  logic [CFG_W-1:0] chk_sec_q;
  logic inv_fire;
  logic chk_fire;

  assign inv_fire = run && sec_tick &&
    (inv_sec_q + CFG_ONE >= cfg.invalidation_cycle_seconds);
  assign chk_fire = run && sec_tick &&
    (chk_sec_q + CFG_ONE >= cfg.validity_check_interval);

  always_ff @(posedge clk) begin
    if (!rstn || !run || inv_fire) begin
      inv_sec_q <= CFG_ZERO;
    end else if (sec_tick) begin
      inv_sec_q <= inv_sec_q + CFG_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !run || chk_fire) begin
      chk_sec_q <= CFG_ZERO;
    end else if (sec_tick) begin
      chk_sec_q <= chk_sec_q + CFG_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      check_pulse <= 1'b0;
      monitor_active <= 1'b0;
    end else begin
      check_pulse <= chk_fire;
      monitor_active <= run;
    end
  end

  // ****************************************
  // per point flags and counters
  // ****************************************
  logic [CFG_W-1:0] fail_cnt_q [N_POINTS];

  for (genvar i = 0; i < N_POINTS; i++) begin : g_pt
    always_ff @(posedge clk) begin
      if (!rstn) begin
        invalid_flag[i] <= 1'b0;
      end else if (inv_fire && flag_addr_nonzero[i]) begin
        invalid_flag[i] <= 1'b1;
      end else if (flag_clear[i]) begin
        invalid_flag[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (!rstn || !run || !flag_addr_nonzero[i]) begin
        fail_cnt_q[i] <= CFG_ZERO;
      end else if (chk_fire) begin
        if (!invalid_flag[i]) begin
          fail_cnt_q[i] <= CFG_ZERO;
        end else if (fail_cnt_q[i] < cfg.failure_threshold) begin
          fail_cnt_q[i] <= fail_cnt_q[i] + CFG_ONE;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        point_invalid[i] <= 1'b0;
      end else begin
        point_invalid[i] <= run && flag_addr_nonzero[i] &&
          (fail_cnt_q[i] >= cfg.failure_threshold);
      end
    end

    a_cnt_clear: assert property (@(posedge clk) disable iff (!rstn)
      run && chk_fire && flag_addr_nonzero[i] && !invalid_flag[i]
      |=> fail_cnt_q[i] == CFG_ZERO)
      else $error("counter not cleared");
    a_excluded: assert property (@(posedge clk) disable iff (!rstn)
      !$past(flag_addr_nonzero[i]) |-> !point_invalid[i])
      else $error("excluded point invalid");
    a_cnt_inc: assert property (@(posedge clk) disable iff (!rstn)
      run && chk_fire && flag_addr_nonzero[i] && invalid_flag[i] &&
      fail_cnt_q[i] < cfg.failure_threshold && enabled
      |=> fail_cnt_q[i] == $past(fail_cnt_q[i]) + CFG_ONE)
      else $error("counter not incremented");
  end

  // ****************************************
  // event scan pacing
  // ****************************************
  logic [CFG_W-1:0] scan_ms_q;
  logic scan_fire;

  assign scan_fire = ms_tick && (cfg.scan_period_ms != CFG_ZERO) &&
    (scan_ms_q + CFG_ONE >= cfg.scan_period_ms);

  always_ff @(posedge clk) begin
    if (!rstn || scan_fire || cfg.scan_period_ms == CFG_ZERO) begin
      scan_ms_q <= CFG_ZERO;
    end else if (ms_tick) begin
      scan_ms_q <= scan_ms_q + CFG_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scan_event <= '0;
    end else begin
      scan_event <= scan_fire ? type_scan_enable : '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_disable_all: assert property (@(posedge clk) disable iff (!rstn)
    !enabled |=> point_invalid == '0)
    else $error("invalid while disabled");
  a_no_scan: assert property (@(posedge clk) disable iff (!rstn)
    cfg.scan_period_ms == CFG_ZERO |=> scan_event == '0)
    else $error("event with zero scan period");
  a_scan_mask: assert property (@(posedge clk) disable iff (!rstn)
    scan_event != '0 |-> (scan_event & ~$past(type_scan_enable)) == '0)
    else $error("event for disabled type");
  a_scan_cause: assert property (@(posedge clk) disable iff (!rstn)
    scan_event != '0 |-> $past(scan_fire))
    else $error("event without scan tick");
  a_set_flags: assert property (@(posedge clk) disable iff (!rstn)
    inv_fire |=> (invalid_flag & $past(flag_addr_nonzero))
    == $past(flag_addr_nonzero))
    else $error("flags not forced");
  a_check_sec: assert property (@(posedge clk) disable iff (!rstn)
    chk_fire |-> chk_sec_q + CFG_ONE == cfg.validity_check_interval)
    else $error("check off interval");

  c_check: cover property (@(posedge clk) chk_fire);
  c_invalid: cover property (@(posedge clk) point_invalid != '0);
  c_recover: cover property (@(posedge clk)
    $fell(point_invalid[0]) && monitor_active);
  c_scan: cover property (@(posedge clk) scan_event != '0);

endmodule : point_validity_monitor

`default_nettype wire

// *** include/pvm_pkg.sv ***
package pvm_pkg;

  // ****************************************
  // time bases
  // ****************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned MS_CYCLES = CLK_MHZ * MS_US;
  localparam int unsigned SEC_MS = 1000;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned CFG_W = 16;
  localparam logic [CFG_W-1:0] CFG_ZERO = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_ONE = 16'h0001;

  // ****************************************
  // monitored point types
  // ****************************************
  localparam int unsigned N_TYPES = 7;

  typedef struct packed {
    logic [CFG_W-1:0] invalidation_cycle_seconds;
    logic [CFG_W-1:0] validity_check_interval;
    logic [CFG_W-1:0] failure_threshold;
    logic [CFG_W-1:0] scan_period_ms;
  } pvm_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_OFF = 3'b100
  } pvm_state_t;

endpackage : pvm_pkg

// *** tb/pvm_app_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pvm_app_model #(
  parameter int unsigned N = 4
) (
  input wire logic clk,
  input wire logic [N-1:0] keep_fresh,
  input wire logic [N-1:0] clear_once,
  output logic [N-1:0] flag_clear
);
  // ****************************************
  // flag clearing by the application
  // ****************************************
  always_ff @(posedge clk) begin
    flag_clear <= keep_fresh | clear_once;
  end
endmodule : pvm_app_model

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb import pvm_pkg::*;;
  logic clk;
  logic rstn = 1'b0;
  pvm_cfg_t cfg = '0;
  logic [3:0] enr = 4'h3;
  logic [3:0] fresh = 4'h2;
  logic [3:0] once = 4'h0;
  logic [6:0] ten = 7'h55;
  logic [3:0] fclr, inv, pinv;
  logic [6:0] sev;
  logic chkp, act;
  int err_total = 0;
  int total_checks = 0;
  int cnt [7];

  // ****************************************
  // clock and instances
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  point_validity_monitor #(.N_POINTS(4), .MS_DIV(4), .SEC_DIV(3))
    i_point_validity_monitor (.clk(clk), .rstn(rstn), .cfg(cfg),
    .flag_addr_nonzero(enr), .flag_clear(fclr), .type_scan_enable(ten),
    .invalid_flag(inv), .point_invalid(pinv), .scan_event(sev),
    .check_pulse(chkp), .monitor_active(act));

  pvm_app_model #(.N(4)) i_pvm_app_model (.clk(clk), .keep_fresh(fresh),
    .clear_once(once), .flag_clear(fclr));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic restart(input pvm_cfg_t c);
    @(posedge clk);
    cfg <= c;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
  endtask : restart

  task automatic wait_check;
    int i;
    for (i = 0; i < 100 && chkp !== 1'b1; i++) @(negedge clk);
    if (chkp !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_check

  task automatic count_scan(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      for (int k = 0; k < 7; k++) cnt[k] += int'(sev[k]);
    end
  endtask : count_scan

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    restart('{16'h0004, 16'h0001, 16'h0002, 16'h0002});
    repeat (3) @(negedge clk);
    check(8'(act), 8'h01);
    repeat (80) @(negedge clk);
    check(8'(pinv), 8'h01);
    check(8'(inv[3:2]), 8'h00);
    check(8'(inv[0]), 8'h01);
    $display("test stale point done");
    wait_check();
    repeat (2) @(negedge clk);
    @(posedge clk) once <= 4'h1;
    @(posedge clk) once <= 4'h0;
    repeat (2) @(negedge clk);
    check(8'(inv[0]), 8'h00);
    check(8'(pinv[0]), 8'h01);
    wait_check();
    repeat (2) @(negedge clk);
    check(8'(pinv), 8'h00);
    $display("test recovery done");
    count_scan(80);
    for (int k = 0; k < 7; k++) check(8'(cnt[k]), ten[k] ? 8'h0a : 8'h00);
    $display("test scan done");
    check(8'(pinv), 8'h01);
    @(posedge clk) cfg.failure_threshold <= CFG_ZERO;
    repeat (2) @(negedge clk);
    check({act, 3'h0, pinv}, 8'h00);
    $display("test mid-run disable done");
    restart('{16'h0001, 16'h0001, 16'h0000, 16'h0000});
    count_scan(60);
    for (int k = 0; k < 7; k++) check(8'(cnt[k]), 8'h00);
    check({act, 3'h0, pinv}, 8'h00);
    $display("test disabled done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
